// [lane_map_pkg.sv]
package lane_map_pkg;

  // ****************************************
  // Byte enable patterns (active low)
  // ****************************************
  localparam logic [3:0] BE_BYTE0  = 4'hE;
  localparam logic [3:0] BE_BYTE1  = 4'hD;
  localparam logic [3:0] BE_BYTE2  = 4'hB;
  localparam logic [3:0] BE_BYTE3  = 4'h7;
  localparam logic [3:0] BE_HALF01 = 4'hC;
  localparam logic [3:0] BE_MID12  = 4'h9;
  localparam logic [3:0] BE_HALF23 = 4'h3;
  localparam logic [3:0] BE_TRI012 = 4'h8;
  localparam logic [3:0] BE_TRI123 = 4'h1;
  localparam logic [3:0] BE_WORD   = 4'h0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ADDR_HI_BIT  = 2;
  localparam int LANE_WIDTH   = 8;
  localparam int LANE_COUNT   = 4;

  // ****************************************
  // Reset values (strobes, LWORD idle high)
  // ****************************************
  localparam logic [1:0]  STROBE_IDLE = 2'h3;
  localparam logic        LWORD_IDLE  = 1'h1;
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;

  // ****************************************
  // Request and answer carriers
  // ****************************************
  typedef enum logic {DIR_PCI_TO_VME, DIR_VME_TO_PCI} dir_t;

  typedef struct packed {
    logic [3:0]  byteEnB;
    logic [2:0]  addrLow;
    logic [31:0] data;
    logic        d64;
    dir_t        dir;
  } pci_side_t;

  typedef struct packed {
    logic [1:0]  strobeB;
    logic        addr1;
    logic        lwordB;
    logic [31:0] data;
    logic [31:0] addrData;
  } vme_side_t;

endpackage

// [pci_vme_byte_lane_mapper.sv]
`timescale 1ns/100ps
// What this block does
// - Data is little-endian; lowest byte address holds the least significant byte.
// - Address-invariant translation always applies; no other swap mode exists.
// - Byte 0 goes to VME D8-D15, byte 1 to D0-D7, A1 low.
// - Byte 2 goes to VME D8-D15, byte 3 to D0-D7, A1 high.
// - Halfwords swap bytes, both strobes low; full word reverses all four lanes.
// - Unaligned three-byte and middle two-byte patterns use reversed lanes, given strobes.
// - A 64-bit beat splits into upper half first, lower half at address bit 2.
// - First 64-bit transfer exchanges PCI bytes with VME address lines, reversed.
// - Second 64-bit transfer exchanges PCI bytes with VME data lanes, reversed.
module pci_vme_byte_lane_mapper
  import lane_map_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // PCI side request
  input  wire logic        reqValid,
  input  wire pci_side_t   pciIn,
  // VME lines for reads
  input  wire logic [31:0] vmeDataIn,
  input  wire logic [31:0] vmeAddrIn,
  // VME side answer
  output      logic        vmeValid,
  output      vme_side_t   vmeOut,
  // PCI side answer
  output      logic [31:0] pciDataOut,
  output      logic        patternError
);

  // ****************************************
  // Lane reversal
  // ****************************************
  logic [31:0] swapPci;
  logic [31:0] swapVme;
  logic [31:0] swapAddr;

  generate
    for (genvar lane = 0; lane < LANE_COUNT; lane++) begin : gLane
      // Each byte lane lands on its mirror lane
      assign swapPci[lane*LANE_WIDTH +: LANE_WIDTH] =
        pciIn.data[(LANE_COUNT-1-lane)*LANE_WIDTH +: LANE_WIDTH];
      assign swapVme[lane*LANE_WIDTH +: LANE_WIDTH] =
        vmeDataIn[(LANE_COUNT-1-lane)*LANE_WIDTH +: LANE_WIDTH];
      assign swapAddr[lane*LANE_WIDTH +: LANE_WIDTH] =
        vmeAddrIn[(LANE_COUNT-1-lane)*LANE_WIDTH +: LANE_WIDTH];
    end
  endgenerate

  // ****************************************
  // Strobe, A1, LWORD decode
  // ****************************************
  logic [1:0]  strobeNext;
  logic        addr1Next;
  logic        lwordNext;
  logic [31:0] dataNext;
  logic        badNext;

  always_comb begin
    strobeNext = STROBE_IDLE;
    addr1Next  = 1'h0;
    lwordNext  = LWORD_IDLE;
    dataNext   = swapPci;
    badNext    = 1'h0;
    unique case (pciIn.byteEnB)
      BE_BYTE0: begin
        strobeNext = 2'h1;
        dataNext   = {16'h0000, pciIn.data[7:0], 8'h00};
      end
      BE_BYTE1: begin
        strobeNext = 2'h2;
        dataNext   = {24'h000000, pciIn.data[15:8]};
      end
      BE_BYTE2: begin
        strobeNext = 2'h1;
        addr1Next  = 1'h1;
        dataNext   = {16'h0000, pciIn.data[23:16], 8'h00};
      end
      BE_BYTE3: begin
        strobeNext = 2'h2;
        addr1Next  = 1'h1;
        dataNext   = {24'h000000, pciIn.data[31:24]};
      end
      BE_HALF01: begin
        strobeNext = 2'h0;
        dataNext   = {16'h0000, pciIn.data[7:0], pciIn.data[15:8]};
      end
      BE_HALF23: begin
        strobeNext = 2'h0;
        addr1Next  = 1'h1;
        dataNext   = {16'h0000, pciIn.data[23:16], pciIn.data[31:24]};
      end
      BE_WORD: begin
        strobeNext = 2'h0;
        lwordNext  = 1'h0;
      end
      BE_MID12: begin
        strobeNext = 2'h0;
        addr1Next  = 1'h1;
        lwordNext  = 1'h0;
        dataNext   = {8'h00, pciIn.data[15:8], pciIn.data[23:16], 8'h00};
      end
      BE_TRI012: begin
        strobeNext = 2'h1;
        lwordNext  = 1'h0;
        dataNext   = {swapPci[31:8], 8'h00};
      end
      BE_TRI123: begin
        strobeNext = 2'h2;
        lwordNext  = 1'h0;
        dataNext   = {8'h00, swapPci[23:0]};
      end
      default: begin
        badNext    = 1'h1;
        dataNext   = DATA_RESET;
      end
    endcase
  end

  // ****************************************
  // Request decode
  // ****************************************
  logic writeReq;
  logic readReq;
  logic firstBeat;

  assign writeReq  = reqValid && pciIn.dir == DIR_PCI_TO_VME;
  assign readReq   = reqValid && pciIn.dir == DIR_VME_TO_PCI;
  // Upper half of a 64-bit beat rides on the address lines
  assign firstBeat = pciIn.d64 && !pciIn.addrLow[ADDR_HI_BIT];

  // ****************************************
  // Answer pulses
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vmeValid <= 1'h0;
    end else begin
      vmeValid <= writeReq;
    end
  end

  // Refusal covers any single transfer with an unlisted pattern
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      patternError <= 1'h0;
    end else begin
      patternError <= reqValid && !pciIn.d64 && badNext;
    end
  end

  // ****************************************
  // Strobes, A1 and LWORD
  // ****************************************
  logic [1:0] strobeReg;
  logic       addr1Reg;
  logic       lwordReg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobeReg <= STROBE_IDLE;
      addr1Reg  <= 1'h0;
      lwordReg  <= LWORD_IDLE;
    end else if (writeReq) begin
      if (pciIn.d64) begin
        // Every lane carries data in both 64-bit beats
        strobeReg <= 2'h0;
        addr1Reg  <= 1'h0;
        lwordReg  <= 1'h0;
      end else begin
        strobeReg <= strobeNext;
        addr1Reg  <= addr1Next;
        lwordReg  <= lwordNext;
      end
    end
  end

  // ****************************************
  // Data and address lines
  // ****************************************
  logic [31:0] lineDataReg;
  logic [31:0] lineAddrReg;

  // Each 64-bit beat leaves the other half of the lines untouched
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineDataReg <= DATA_RESET;
    end else if (writeReq) begin
      if (!pciIn.d64) begin
        lineDataReg <= dataNext;
      end else if (!firstBeat) begin
        lineDataReg <= swapPci;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lineAddrReg <= DATA_RESET;
    end else if (writeReq && firstBeat) begin
      lineAddrReg <= swapPci;
    end
  end

  // ****************************************
  // VME side carrier
  // ****************************************
  assign vmeOut = '{strobeB:  strobeReg,
                    addr1:    addr1Reg,
                    lwordB:   lwordReg,
                    data:     lineDataReg,
                    addrData: lineAddrReg};

  // ****************************************
  // Registered PCI read data
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pciDataOut <= DATA_RESET;
    end else if (readReq) begin
      if (firstBeat) begin
        pciDataOut <= swapAddr;
      end else begin
        pciDataOut <= swapVme;
      end
    end
  end

endmodule

// [pci_vme_byte_lane_mapper_checker.sv]
`timescale 1ns/100ps
// ****
// Lane mapping checks
// ****
module pci_vme_byte_lane_mapper_checker
  import lane_map_pkg::*;
(
  // Inputs
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        reqValid,
  input wire pci_side_t   pciIn,
  input wire logic [31:0] vmeDataIn,
  // Outputs
  input wire logic        vmeValid,
  input wire vme_side_t   vmeOut,
  input wire logic [31:0] pciDataOut,
  input wire logic        patternError
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  function automatic logic [31:0] flip(logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  wire logic wrReq = reqValid && pciIn.dir == DIR_PCI_TO_VME && !pciIn.d64;
  wire logic hiReq = reqValid && pciIn.dir == DIR_PCI_TO_VME && pciIn.d64;
  wire logic badBe = !(pciIn.byteEnB inside {BE_BYTE0, BE_BYTE1, BE_BYTE2, BE_BYTE3, BE_HALF01,
    BE_MID12, BE_HALF23, BE_TRI012, BE_TRI123, BE_WORD});
  property p_valid; reqValid && pciIn.dir == DIR_PCI_TO_VME |=> vmeValid; endproperty
  a_valid: assert property (p_valid) else $error("write not answered");
  property p_byte0; wrReq && pciIn.byteEnB == BE_BYTE0 |=> vmeOut.strobeB == 2'h1
    && vmeOut.data == {16'h0, $past(pciIn.data[7:0]), 8'h0}; endproperty
  a_byte0: assert property (p_byte0) else $error("byte 0 lane");
  property p_byte3; wrReq && pciIn.byteEnB == BE_BYTE3 |=> vmeOut.addr1
    && vmeOut.data == {24'h0, $past(pciIn.data[31:24])}; endproperty
  a_byte3: assert property (p_byte3) else $error("byte 3 lane");
  property p_word; wrReq && pciIn.byteEnB == BE_WORD |=> vmeOut.strobeB == 2'h0
    && !vmeOut.lwordB && vmeOut.data == flip($past(pciIn.data)); endproperty
  a_word: assert property (p_word) else $error("word lanes");
  property p_mid; wrReq && pciIn.byteEnB == BE_MID12 |=> !vmeOut.lwordB && vmeOut.addr1
    && vmeOut.data[23:8] == {$past(pciIn.data[15:8]), $past(pciIn.data[23:16])}; endproperty
  a_mid: assert property (p_mid) else $error("middle pair lanes");
  property p_hi64; hiReq && !pciIn.addrLow[2] |=> $stable(vmeOut.data)
    && vmeOut.addrData == flip($past(pciIn.data)); endproperty
  a_hi64: assert property (p_hi64) else $error("upper beat");
  property p_lo64; hiReq && pciIn.addrLow[2] |=> $stable(vmeOut.addrData)
    && vmeOut.data == flip($past(pciIn.data)); endproperty
  a_lo64: assert property (p_lo64) else $error("lower beat");
  property p_read; reqValid && pciIn.dir == DIR_VME_TO_PCI && !pciIn.d64
    |=> pciDataOut == flip($past(vmeDataIn)); endproperty
  a_read: assert property (p_read) else $error("read lanes");
  property p_refuse; wrReq && badBe |=> patternError && vmeOut.strobeB == STROBE_IDLE
    && vmeOut.lwordB && !vmeOut.addr1 && vmeOut.data == 32'h0; endproperty
  a_refuse: assert property (p_refuse) else $error("refused pattern");
  property p_quiet; !(reqValid && pciIn.dir == DIR_PCI_TO_VME) |=> !vmeValid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without write");
  c_hi: cover property (hiReq);
  c_refuse: cover property (wrReq && badBe);
  c_mid: cover property (wrReq && pciIn.byteEnB == BE_MID12);
  c_read: cover property (reqValid && pciIn.dir == DIR_VME_TO_PCI);
endmodule

// [vme_board_model.sv]
`timescale 1ns/100ps
// ****
// VME board answering reads
// ****
module vme_board_model (
  // Control
  input  wire logic [31:0] word,
  input  wire logic        drive,
  // VME lines
  output logic [31:0]      dataLines,
  output logic [31:0]      addrLines
);
  // Released data lines never keep the word; released address lines carry it unchanged
  assign dataLines = drive ? word : ~word;
  assign addrLines = drive ? ~word : word;
endmodule

// [pci_vme_byte_lane_mapper_tb_top.sv]
`timescale 1ns/100ps
// ****
// Bench
// ****
module pci_vme_byte_lane_mapper_tb_top;
  import lane_map_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b, reqValid, drive, vmeValid, patternError;
  pci_side_t pciIn;
  vme_side_t vmeOut;
  logic [31:0] word, vmeDataIn, vmeAddrIn, pciDataOut;
  int bad_count = 0;
  int tests_run = 0;
  logic [39:0] rows [10] = '{40'hE5_00001100, 40'hD9_00000022, 40'hB7_00003300,
    40'h7B_00000044, 40'hC1_00001122, 40'h92_00223300, 40'h33_00003344,
    40'h84_11223300, 40'h18_00223344, 40'h00_11223344};
  always #10 ref_clk = ~ref_clk;
  pci_vme_byte_lane_mapper u_pci_vme_byte_lane_mapper (.ref_clk(ref_clk), .rst_b(rst_b),
    .reqValid(reqValid), .pciIn(pciIn), .vmeDataIn(vmeDataIn), .vmeAddrIn(vmeAddrIn),
    .vmeValid(vmeValid), .vmeOut(vmeOut), .pciDataOut(pciDataOut),
    .patternError(patternError));
  vme_board_model u_vme_board_model (.word(word), .drive(drive), .dataLines(vmeDataIn),
    .addrLines(vmeAddrIn));
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic req(logic [3:0] be, logic [2:0] al, logic [31:0] d, logic w, dir_t dr);
    @(negedge ref_clk);
    pciIn = '{be, al, d, w, dr};
    reqValid = 1'b1;
    @(negedge ref_clk);
    reqValid = 1'b0;
  endtask
  task automatic t_table;
    for (int i = 0; i < 10; i++) begin
      req(rows[i][39:36], 3'h0, 32'h44332211, 1'b0, DIR_PCI_TO_VME);
      chk(vmeOut.data, rows[i][31:0]);
      chk({vmeOut.strobeB, vmeOut.addr1, vmeOut.lwordB}, rows[i][35:32]);
      chk(vmeValid, 1'b1);
    end
  endtask
  task automatic t_refuse;
    req(4'hA, 3'h0, 32'h44332211, 1'b0, DIR_PCI_TO_VME);
    chk(patternError, 1'b1);
    chk(vmeOut.data, 32'h0);
    chk(vmeOut.strobeB, STROBE_IDLE);
    chk({vmeValid, vmeOut.addr1, vmeOut.lwordB}, 32'h5);
  endtask
  task automatic t_d64;
    req(BE_WORD, 3'h0, 32'h44332211, 1'b1, DIR_PCI_TO_VME);
    chk(vmeOut.addrData, 32'h11223344);
    chk({vmeOut.strobeB, vmeOut.addr1, vmeOut.lwordB}, 32'h0);
    req(BE_WORD, 3'h4, 32'hA1B2C3D4, 1'b1, DIR_PCI_TO_VME);
    chk(vmeOut.data, 32'hD4C3B2A1);
    chk(vmeOut.addrData, 32'h11223344);
  endtask
  task automatic t_read;
    drive = 1'b1;
    word = 32'h11223344;
    req(BE_WORD, 3'h0, 32'h0, 1'b0, DIR_VME_TO_PCI);
    chk(pciDataOut, 32'h44332211);
    chk(vmeValid, 1'b0);
    req(BE_WORD, 3'h0, 32'h0, 1'b1, DIR_VME_TO_PCI);
    chk(pciDataOut, 32'hBBCCDDEE);
    req(BE_WORD, 3'h4, 32'h0, 1'b1, DIR_VME_TO_PCI);
    chk(pciDataOut, 32'h44332211);
    drive = 1'b0;
  endtask
  task automatic t_reset;
    req(BE_WORD, 3'h0, 32'h44332211, 1'b0, DIR_PCI_TO_VME);
    rst_b = 1'b0;
    @(negedge ref_clk);
    chk({vmeValid, patternError, vmeOut.strobeB, vmeOut.addr1, vmeOut.lwordB}, 32'h0D);
    chk(vmeOut.data, 32'h0);
    chk(vmeOut.addrData, 32'h0);
    chk(pciDataOut, 32'h0);
    rst_b = 1'b1;
    req(BE_BYTE0, 3'h0, 32'h000000AB, 1'b0, DIR_PCI_TO_VME);
    chk(vmeOut.data, 32'h0000AB00);
    chk({vmeValid, vmeOut.strobeB, vmeOut.addr1, vmeOut.lwordB}, 32'h15);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    reqValid = 1'b0;
    pciIn = '0;
    drive = 1'b0;
    word = 32'h0;
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    t_table();
    t_refuse();
    t_d64();
    t_read();
    t_reset();
    print_verdict();
  end
  initial begin
    #4000;
    bad_count++;
    print_verdict();
  end
endmodule
bind pci_vme_byte_lane_mapper pci_vme_byte_lane_mapper_checker u_checker (.ref_clk(ref_clk),
  .rst_b(rst_b), .reqValid(reqValid), .pciIn(pciIn), .vmeDataIn(vmeDataIn),
  .vmeValid(vmeValid), .vmeOut(vmeOut), .pciDataOut(pciDataOut), .patternError(patternError));
